// [verilog/drdac_map.vh]
// address, instruction field and preset constants for the dual wiper latch slave
`ifndef DRDAC_MAP_VH
`define DRDAC_MAP_VH
`define DRDAC_ADDR_FIXED   5'h0b
`define DRDAC_INS_CHAN     7
`define DRDAC_INS_MID      6
`define DRDAC_INS_SHUTDOWN_PIN_N     5
`define DRDAC_INS_GP1      4
`define DRDAC_INS_GP2      3
`define DRDAC_MIDSCALE     8'h80
`define DRDAC_BYTE_BITS    4'h8
`endif

// [verilog/drdac_sync.v]
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module drdac_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire rst_val_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= rst_val_i;
      q_o  <= rst_val_i;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
  // reset level per pin matches its idle level, so no false edge follows reset
endmodule // drdac_sync

// [verilog/drdac_chan.v]
// one wiper latch channel; shutdown drives the open and tie outputs, not the code
`timescale 1ns/1ps
`include "drdac_map.vh"
module drdac_chan (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       load_i,
  input  wire       mid_i,
  input  wire [7:0] data_i,
  input  wire       shutdown_pin_n_i,
  output reg  [7:0] latch_o,
  output reg        open_a_o,
  output reg        wiper_b_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch_o   <= `DRDAC_MIDSCALE;
      open_a_o  <= 1'b0;
      wiper_b_o <= 1'b0;
    end else begin
      if (mid_i)
        latch_o <= `DRDAC_MIDSCALE;
      else if (load_i)
        latch_o <= data_i;
      open_a_o  <= shutdown_pin_n_i;
      wiper_b_o <= shutdown_pin_n_i;
    end
  end
endmodule // drdac_chan

// [verilog/drdac_top.v]
// two-wire slave controlling two wiper latches and two logic outputs
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "drdac_map.vh"
module drdac_top (
  input  wire       REF_CLK_I,
  input  wire       RESET_I,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output reg        SDA_O,
  output reg        SDA_OE_O,
  input  wire       ADDR_STRAP_LSB_I,
  input  wire       ADDR_STRAP_MSB_I,
  input  wire       SHUTDOWN_PIN_N_I,
  output reg  [7:0] WIPER_LATCH1_O,
  output reg  [7:0] WIPER_LATCH2_O,
  output reg        OPEN_A1_O,
  output reg        OPEN_A2_O,
  output reg        WIPER_TO_B1_O,
  output reg        WIPER_TO_B2_O,
  output reg        GP_OUT_FIRST_O,
  output reg        GP_OUT_SECOND_O
);
  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_INS  = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_RD   = 3'h4;
  localparam ST_ACK  = 3'h5;
  localparam ST_RACK = 3'h6;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  wire shutdown_pin_n_n_s;
  wire str_lsb_s;
  wire str_msb_s;

  drdac_sync u_scl (.clk_i(REF_CLK_I), .rst_i(RESET_I), .rst_val_i(1'b1), .d_i(SCL_I),
                    .q_o(scl_s));
  drdac_sync u_sda (.clk_i(REF_CLK_I), .rst_i(RESET_I), .rst_val_i(1'b1), .d_i(SDA_I),
                    .q_o(sda_s));
  drdac_sync u_shd (.clk_i(REF_CLK_I), .rst_i(RESET_I), .rst_val_i(1'b1),
                    .d_i(SHUTDOWN_PIN_N_I), .q_o(shutdown_pin_n_n_s));
  drdac_sync u_al  (.clk_i(REF_CLK_I), .rst_i(RESET_I), .rst_val_i(1'b1),
                    .d_i(ADDR_STRAP_LSB_I), .q_o(str_lsb_s));
  drdac_sync u_am  (.clk_i(REF_CLK_I), .rst_i(RESET_I), .rst_val_i(1'b1),
                    .d_i(ADDR_STRAP_MSB_I), .q_o(str_msb_s));

  // ----------------------------------------------------------------
  // edge and condition detection
  // ----------------------------------------------------------------
  reg scl_d;
  reg sda_d;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // start and stop are sda moving while scl stays high; data never moves then
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [2:0] ret;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] ins;
  reg       mid_pend;
  reg       sd_ch1;
  reg       sd_ch2;
  reg       load1;
  reg       load2;
  reg       mid1;
  reg       mid2;
  reg       rd_nack;

  wire [7:0] lat1;
  wire [7:0] lat2;
  wire       oa1;
  wire       oa2;
  wire       wb1;
  wire       wb2;
  // reads return the latch of the last instruction's channel, channel one after reset
  wire [7:0] rd_byte = ins[`DRDAC_INS_CHAN] ? lat2 : lat1;
  wire [6:0] my_addr = {`DRDAC_ADDR_FIXED, str_msb_s, str_lsb_s};

  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      state    <= ST_IDLE;
      ret      <= ST_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      ins      <= 8'h00;
      mid_pend <= 1'b0;
      sd_ch1   <= 1'b0;
      sd_ch2   <= 1'b0;
      load1    <= 1'b0;
      load2    <= 1'b0;
      mid1     <= 1'b0;
      mid2     <= 1'b0;
      rd_nack  <= 1'b0;
      SDA_O    <= 1'b0;
      SDA_OE_O <= 1'b0;
      GP_OUT_FIRST_O  <= 1'b0;
      GP_OUT_SECOND_O <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      load1 <= 1'b0;
      load2 <= 1'b0;
      mid1  <= 1'b0;
      mid2  <= 1'b0;
      if (start_c) begin
        state    <= ST_ADDR;
        bitcnt   <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else if (stop_c) begin
        state    <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            SDA_OE_O <= 1'b0;
          end
          ST_ADDR, ST_INS, ST_DATA: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == `DRDAC_BYTE_BITS) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == my_addr) begin
                  SDA_OE_O <= 1'b1;
                  if (shreg[0]) begin
                    ret <= ST_RD;
                  end else begin
                    ret <= ST_INS;
                  end
                  state <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_INS) begin
                // low three bits are don't care
                ins      <= shreg;
                mid_pend <= shreg[`DRDAC_INS_MID];
                // each channel keeps its own shutdown bit until it is addressed again
                if (shreg[`DRDAC_INS_CHAN]) begin
                  sd_ch2 <= shreg[`DRDAC_INS_SHUTDOWN_PIN_N];
                end else begin
                  sd_ch1 <= shreg[`DRDAC_INS_SHUTDOWN_PIN_N];
                end
                GP_OUT_FIRST_O  <= shreg[`DRDAC_INS_GP1];
                GP_OUT_SECOND_O <= shreg[`DRDAC_INS_GP2];
                if (shreg[`DRDAC_INS_MID]) begin
                  mid1 <= ~shreg[`DRDAC_INS_CHAN];
                  mid2 <= shreg[`DRDAC_INS_CHAN];
                end
                SDA_OE_O <= 1'b1;
                ret      <= ST_DATA;
                state    <= ST_ACK;
              end else begin
                // midscale instruction holds the latch at centre for each data byte
                if (mid_pend) begin
                  mid1 <= ~ins[`DRDAC_INS_CHAN];
                  mid2 <= ins[`DRDAC_INS_CHAN];
                end else begin
                  load1 <= ~ins[`DRDAC_INS_CHAN];
                  load2 <= ins[`DRDAC_INS_CHAN];
                end
                SDA_OE_O <= 1'b1;
                ret      <= ST_DATA;
                state    <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            SDA_O <= 1'b0;
            if (scl_fall) begin
              if (ret == ST_RD) begin
                // first data bit driven straight after the address ack
                SDA_OE_O <= ~rd_byte[7];
                shreg    <= {rd_byte[6:0], 1'b0};
                bitcnt   <= 4'h1;
              end else begin
                SDA_OE_O <= 1'b0;
                bitcnt   <= 4'h0;
              end
              state <= ret;
            end
          end
          ST_RD: begin
            // open drain: enable only to pull low
            if (scl_fall) begin
              if (bitcnt == `DRDAC_BYTE_BITS) begin
                SDA_OE_O <= 1'b0;
                state    <= ST_RACK;
              end else begin
                SDA_OE_O <= ~shreg[7];
                shreg    <= {shreg[6:0], 1'b0};
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise)
              rd_nack <= sda_s;
            if (scl_fall) begin
              if (rd_nack) begin
                state <= ST_IDLE;
              end else begin
                // master acked: repeated read of the same latch
                SDA_OE_O <= ~rd_byte[7];
                shreg    <= {rd_byte[6:0], 1'b0};
                bitcnt   <= 4'h1;
                state    <= ST_RD;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // wiper latches; code 0 sits beside B, each step one tap toward A
  // ----------------------------------------------------------------
  // the pin shuts both channels, the instruction bit only its own one
  wire sd1 = ~shutdown_pin_n_n_s | sd_ch1;
  wire sd2 = ~shutdown_pin_n_n_s | sd_ch2;

  drdac_chan u_ch1 (
    .clk_i     (REF_CLK_I),
    .rst_i     (RESET_I),
    .load_i    (load1),
    .mid_i     (mid1),
    .data_i    (shreg),
    .shutdown_pin_n_i    (sd1),
    .latch_o   (lat1),
    .open_a_o  (oa1),
    .wiper_b_o (wb1)
  );
  drdac_chan u_ch2 (
    .clk_i     (REF_CLK_I),
    .rst_i     (RESET_I),
    .load_i    (load2),
    .mid_i     (mid2),
    .data_i    (shreg),
    .shutdown_pin_n_i    (sd2),
    .latch_o   (lat2),
    .open_a_o  (oa2),
    .wiper_b_o (wb2)
  );

  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      WIPER_LATCH1_O <= `DRDAC_MIDSCALE;
      WIPER_LATCH2_O <= `DRDAC_MIDSCALE;
      OPEN_A1_O      <= 1'b0;
      OPEN_A2_O      <= 1'b0;
      WIPER_TO_B1_O  <= 1'b0;
      WIPER_TO_B2_O  <= 1'b0;
    end else begin
      // latch value passes unchanged in shutdown so the wiper returns afterwards
      WIPER_LATCH1_O <= lat1;
      WIPER_LATCH2_O <= lat2;
      OPEN_A1_O      <= oa1;
      OPEN_A2_O      <= oa2;
      WIPER_TO_B1_O  <= wb1;
      WIPER_TO_B2_O  <= wb2;
    end
  end
endmodule // drdac_top

// [test/drdac_top_asserts.sv]
// port checks for the dual wiper latch slave
`timescale 1ns/1ps
module drdac_top_asserts (
  input wire       REF_CLK_I,
  input wire       RESET_I,
  input wire       SCL_I,
  input wire       SDA_O,
  input wire       SDA_OE_O,
  input wire       SHUTDOWN_PIN_N_I,
  input wire [7:0] WIPER_LATCH1_O,
  input wire [7:0] WIPER_LATCH2_O,
  input wire       OPEN_A1_O,
  input wire       OPEN_A2_O,
  input wire       WIPER_TO_B1_O,
  input wire       WIPER_TO_B2_O,
  input wire       GP_OUT_FIRST_O,
  input wire       GP_OUT_SECOND_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // ----
  // idle and shutdown spans
  // ----
  // long enough that any update queued behind the pin synchronisers has landed
  sequence scl_held;
    SCL_I [*8];
  endsequence
  sequence pin_held;
    !SHUTDOWN_PIN_N_I [*8];
  endsequence
  a_reset_mid: assert property (
    $fell(RESET_I) |-> WIPER_LATCH1_O == 8'h80 && WIPER_LATCH2_O == 8'h80)
    else $error("latches not at midscale after reset");
  a_pin_shuts_all: assert property (
    pin_held |-> OPEN_A1_O && OPEN_A2_O && WIPER_TO_B1_O && WIPER_TO_B2_O)
    else $error("shutdown pin did not shut both channels");
  a_tie_one: assert property (OPEN_A1_O == WIPER_TO_B1_O)
    else $error("channel one open and tie disagree");
  a_tie_two: assert property (OPEN_A2_O == WIPER_TO_B2_O)
    else $error("channel two open and tie disagree");
  a_ack_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data line drive changed while clock high");
  a_drive_low: assert property (SDA_OE_O |-> !SDA_O)
    else $error("data line driven high");
  a_latch_hold: assert property (
    scl_held |-> $stable(WIPER_LATCH1_O) && $stable(WIPER_LATCH2_O))
    else $error("latch moved with bus idle");
  a_gp_hold: assert property (
    scl_held |-> $stable({GP_OUT_FIRST_O, GP_OUT_SECOND_O}))
    else $error("logic output moved with bus idle");
endmodule // drdac_top_asserts

bind drdac_top drdac_top_asserts u_chk (.REF_CLK_I, .RESET_I, .SCL_I, .SDA_O, .SDA_OE_O,
  .SHUTDOWN_PIN_N_I, .WIPER_LATCH1_O, .WIPER_LATCH2_O, .OPEN_A1_O, .OPEN_A2_O,
  .WIPER_TO_B1_O, .WIPER_TO_B2_O, .GP_OUT_FIRST_O, .GP_OUT_SECOND_O);

// [test/drdac_mst_model.sv]
// two-wire bus master model facing the slave
`timescale 1ns/1ps
module drdac_mst_model (
  output reg  scl_o,
  output reg  sda_o,
  input  wire sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data moves only while the clock is low; one bit every 64 ns
  task bit_io(input b, output r);
    begin
      sda_o = b;
      #16 scl_o = 1'b1;
      #16 r = sda_i;
      #16 scl_o = 1'b0;
      #16;
    end
  endtask
  task start;
    begin
      #32 sda_o = 1'b0;
      #32 scl_o = 1'b0;
      #16;
    end
  endtask
  task stop;
    begin
      sda_o = 1'b0;
      #16 scl_o = 1'b1;
      #32 sda_o = 1'b1;
      #32;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input nack, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
      bit_io(nack, r);
    end
  endtask
endmodule // drdac_mst_model

// [test/tb_top.sv]
// self-checking bench for the dual wiper latch slave
`timescale 1ns/1ps
module tb_top;
  reg         clk, rst, shutdown_pin_n_n, ack;
  reg  [1:0]  strap;
  reg  [7:0]  rd, dat;
  reg  [31:0] r;
  reg  [7:0]  exp_lat [0:1];
  reg         last_ch;
  reg  [1:0]  exp_sd;
  integer     err_count, total_checks, i;
  wire        scl, m_sda, sda_o, sda_oe, oa1, oa2, wb1, wb2, gp1, gp2;
  wire [7:0]  lat1, lat2;
  // open drain with pull-up
  wire        sda = m_sda & (sda_oe ? sda_o : 1'b1);
  drdac_top dut (.REF_CLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .ADDR_STRAP_LSB_I(strap[0]), .ADDR_STRAP_MSB_I(strap[1]),
    .SHUTDOWN_PIN_N_I(shutdown_pin_n_n), .WIPER_LATCH1_O(lat1), .WIPER_LATCH2_O(lat2),
    .OPEN_A1_O(oa1), .OPEN_A2_O(oa2), .WIPER_TO_B1_O(wb1), .WIPER_TO_B2_O(wb2),
    .GP_OUT_FIRST_O(gp1), .GP_OUT_SECOND_O(gp2));
  drdac_mst_model mst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
  always #2.5 clk = ~clk;
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (err_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  function [7:0] exp_code(input mid, input [7:0] d);
    exp_code = mid ? 8'h80 : d;
  endfunction
  task wr(input c, input mid, input sd, input a, input b, input [7:0] d0, input [7:0] d1,
          input two);
    begin
      mst.start;
      mst.wbyte({5'h0b, strap, 1'b0}, ack);
      chk(ack, 1'b1);
      mst.wbyte({c, mid, sd, a, b, 3'b101}, ack);
      chk(ack, 1'b1);
      mst.wbyte(d0, ack);
      chk(ack, 1'b1);
      if (two) begin
        mst.wbyte(d1, ack);
        chk(ack, 1'b1);
      end
      mst.stop;
      exp_lat[c] = exp_code(mid, two ? d1 : d0);
      exp_sd[c]  = sd;
      last_ch    = c;
      #50;
      chk(lat1, exp_lat[0]);
      chk(lat2, exp_lat[1]);
      chk({gp1, gp2}, {a, b});
      chk({oa1, wb1, oa2, wb2}, {exp_sd[0], exp_sd[0], exp_sd[1], exp_sd[1]});
    end
  endtask
  task rd_chk;
    begin
      mst.start;
      mst.wbyte({5'h0b, strap, 1'b1}, ack);
      chk(ack, 1'b1);
      // an acknowledge from the master asks for the same latch again
      mst.rbyte(1'b0, rd);
      chk(rd, exp_lat[last_ch]);
      mst.rbyte(1'b1, rd);
      mst.stop;
      chk({ack, rd}, {1'b1, exp_lat[last_ch]});
    end
  endtask
  initial begin
    #200000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    clk = 0; rst = 1; strap = 0; shutdown_pin_n_n = 1; err_count = 0; total_checks = 0; last_ch = 0;
    exp_lat[0] = 8'h80;
    exp_lat[1] = 8'h80;
    exp_sd     = 2'b00;
    r = $urandom(35089);
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (4) @(negedge clk);
    chk(lat1, 8'h80);
    chk(lat2, 8'h80);
    rd_chk;
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      @(negedge clk) strap = i[1:0];
      repeat (4) @(negedge clk);
      dat = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[15:8];
      wr(r[0], 1'b0, 1'b0, r[1], r[2], dat, r[23:16], i[2]);
      rd_chk;
      // a neighbour address must be left alone
      mst.start;
      mst.wbyte({(i[0] ? 5'h0b : 5'h0a), ~strap, 1'b0}, ack);
      chk(ack, 1'b0);
      mst.wbyte(8'h40, ack);
      mst.stop;
      chk({lat1, lat2}, {exp_lat[0], exp_lat[1]});
    end
    // reset in mid-run must bring both latches back to centre
    @(negedge clk) rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    exp_lat[0] = 8'h80;
    exp_lat[1] = 8'h80;
    exp_sd     = 2'b00;
    last_ch    = 1'b0;
    repeat (4) @(negedge clk);
    chk({lat1, lat2}, 16'h8080);
    rd_chk;
    wr(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h11, 8'h22, 1'b1);
    wr(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h3c, 8'h00, 1'b0);
    wr(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h5a, 8'h00, 1'b0);
    rd_chk;
    wr(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'hc3, 8'h00, 1'b0);
    wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'ha5, 8'h00, 1'b0);
    @(negedge clk) shutdown_pin_n_n = 0;
    repeat (10) @(negedge clk);
    chk({oa1, oa2, wb1, wb2}, 4'hf);
    chk({lat1, lat2}, {exp_lat[0], exp_lat[1]});
    shutdown_pin_n_n = 1;
    repeat (10) @(negedge clk);
    chk({oa1, oa2, wb1, wb2}, 4'h0);
    tally_and_finish;
  end
endmodule // tb_top
